// ### hw/rhi_dev.sv
// Operation
// - only parallel or spi, never both
// - straps at power up pick spi variant
// - device is slave, never starts transfers
// - host makes clock and framing
// - device drives service request output
// - spi pins: mosi, miso, active-low select
// - direct mode: data and bit strobe out
// - read indicator high during single-read byte
// - host clocks header then eight more
// - no buffer access in spi without select
// - start then one eight-bit header
// - header top bit: address or command
// - bit six read/write; command zeros there
// - low five bits give register address
// - low five bits give command code
// - data bytes follow an address header
// - continuous mode increments address per byte, except at the buffer address
// - single mode moves exactly one byte
// - host uses continuous for long buffer writes
// - top line rise, clock high: start
// - simple and continuous stop conditions
// - buffer sits at address 1F, 127 bytes
`timescale 1ns/1ps
module rhi_dev import rhi_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	rhi_if.device lnk,
	output logic [4:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input wire logic [7:0] reg_rdata,
	output logic cmd_valid,
	output logic [4:0] cmd_code,
	input wire logic irq_req,
	input wire logic direct_enter,
	input wire logic direct_data,
	input wire logic direct_bitclk,
	output logic direct_active,
	output logic mode_valid,
	output rhi_mode_e iface_mode
);
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_HDR = 3'b001,
		D_WR = 3'b010,
		D_RD = 3'b011,
		D_DONE = 3'b100
	} rhi_dstate_e;

	logic [8:0] pin_q;
	logic [8:0] pin_rise;
	logic [8:0] pin_fall;
	logic [2:0] strap_cnt_q;
	rhi_dstate_e state_q;
	rhi_dstate_e fin_state;
	logic cont_q;
	logic rd_ind_q;
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic [7:0] tx_q;
	logic step_q;
	logic step_d1_q;
	logic re_d1_q;
	logic armed_q;
	logic [2:0] guard_q;
	logic [7:0] out_q;
	logic [7:0] oe_q;
	logic irq_q;
	logic is_par;
	logic is_spi;
	logic quiet;
	logic clk_lvl;
	logic start_ev;
	logic stop_ev;
	logic smpl_stop;
	logic byte_done;
	logic [7:0] byte_c;

	// buffer is out of reach without select
	function automatic logic acc_ok(input rhi_mode_e m, input logic [4:0] a);
		acc_ok = !(m == RHI_SPI_NOSS && a == FIFO_ADDR);
	endfunction

	// clock and all eight lines come from the host's domain
	rhi_sync #(.W(9)) u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.d({lnk.link_clk, lnk.io}),
		.q(pin_q),
		.rise(pin_rise),
		.fall(pin_fall)
	);

	// straps taken once, a few cycles after reset lets go
	always_ff @(posedge core_clk) begin
		if (srst) begin
			strap_cnt_q <= 3'h0;
			mode_valid <= 1'b0;
			iface_mode <= RHI_PAR;
		end else if (!mode_valid) begin
			if (strap_cnt_q == 3'(STRAP_WAIT_CYC - 1)) begin
				mode_valid <= 1'b1;
				unique case (pin_q[2:0])
					STRAP_SPI_SS: iface_mode <= RHI_SPI_SS;
					STRAP_SPI_NOSS: iface_mode <= RHI_SPI_NOSS;
					default: iface_mode <= RHI_PAR;
				endcase
			end else begin
				strap_cnt_q <= strap_cnt_q + 3'h1;
			end
		end
	end

	// frame conditions, all seen through the synchroniser
	always_comb begin
		is_par = mode_valid && iface_mode == RHI_PAR;
		is_spi = mode_valid && iface_mode != RHI_PAR;
		clk_lvl = pin_q[8];
		quiet = guard_q == 3'h0;
		start_ev = 1'b0;
		stop_ev = 1'b0;
		smpl_stop = 1'b0;
		if (is_par && quiet) begin
			start_ev = pin_rise[PIN_TOP] && clk_lvl;
			smpl_stop = pin_fall[PIN_TOP] && clk_lvl;
			stop_ev = smpl_stop || (pin_fall[PIN_TOP] && !clk_lvl && armed_q);
		end else if (mode_valid && iface_mode == RHI_SPI_SS) begin
			start_ev = pin_fall[PIN_SS];
			stop_ev = pin_rise[PIN_SS];
		end
		fin_state = (iface_mode == RHI_SPI_NOSS) ? D_HDR : D_DONE;
		byte_c = is_par ? pin_q[7:0] : {sh_q[6:0], pin_q[PIN_MOSI]};
		byte_done = pin_rise[8] && state_q != D_IDLE && (is_par ? !direct_active : bit_q == 3'h7);
	end

	// continuous stop needs a rise then a fall within one low phase
	always_ff @(posedge core_clk) begin
		if (srst || !is_par || pin_rise[8] || start_ev || stop_ev) begin
			armed_q <= 1'b0;
		end else if (pin_rise[PIN_TOP] && !clk_lvl && quiet) begin
			armed_q <= 1'b1;
		end
	end

	// own release of the top line must not look like a stop
	always_ff @(posedge core_clk) begin
		if (srst) begin
			guard_q <= 3'h0;
		end else if (oe_q[PIN_TOP]) begin
			guard_q <= 3'(PAR_GUARD_CYC);
		end else if (guard_q != 3'h0) begin
			guard_q <= guard_q - 3'h1;
		end
	end

	// direct mode is left only by a simple stop
	always_ff @(posedge core_clk) begin
		if (srst || !is_par) begin
			direct_active <= 1'b0;
		end else if (direct_enter) begin
			direct_active <= 1'b1;
		end else if (smpl_stop) begin
			direct_active <= 1'b0;
		end
	end

	// serial shift in, one bit per host clock rise
	always_ff @(posedge core_clk) begin
		if (srst || start_ev || stop_ev || state_q == D_IDLE) begin
			bit_q <= 3'h0;
			sh_q <= 8'h00;
		end else if (is_spi && pin_rise[8]) begin
			bit_q <= bit_q + 3'h1;
			sh_q <= {sh_q[6:0], pin_q[PIN_MOSI]};
		end
	end

	// transaction engine: header decode, then data bytes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_q <= D_IDLE;
			cont_q <= 1'b0;
			rd_ind_q <= 1'b0;
			step_q <= 1'b0;
			reg_addr <= 5'h00;
			reg_wdata <= 8'h00;
			reg_we <= 1'b0;
			reg_re <= 1'b0;
			cmd_valid <= 1'b0;
			cmd_code <= 5'h00;
		end else begin
			reg_we <= 1'b0;
			reg_re <= 1'b0;
			cmd_valid <= 1'b0;
			step_q <= 1'b0;
			// burst address moves on only after the strobe went out with it
			if (reg_we && cont_q) begin
				reg_addr <= rhi_next_addr(reg_addr);
			end
			if (!mode_valid) begin
				state_q <= D_IDLE;
			end else if (stop_ev) begin
				state_q <= D_IDLE;
				rd_ind_q <= 1'b0;
			end else if (start_ev) begin
				state_q <= D_HDR;
				rd_ind_q <= 1'b0;
			end else if (iface_mode == RHI_SPI_NOSS && state_q == D_IDLE) begin
				state_q <= D_HDR;
			end else if (byte_done) begin
				unique case (state_q)
					D_HDR: begin
						if (byte_c[HDR_CMD_BIT]) begin
							// a command with bit six or five set is dropped
							cmd_valid <= byte_c[6:5] == 2'b00;
							cmd_code <= byte_c[4:0];
							state_q <= fin_state;
						end else begin
							reg_addr <= byte_c[4:0];
							cont_q <= byte_c[HDR_CONT_BIT];
							if (byte_c[HDR_RD_BIT]) begin
								state_q <= D_RD;
								step_q <= 1'b1;
								reg_re <= acc_ok(iface_mode, byte_c[4:0]);
								rd_ind_q <= is_spi && !byte_c[HDR_CONT_BIT];
							end else begin
								state_q <= D_WR;
							end
						end
					end
					D_WR: begin
						reg_we <= acc_ok(iface_mode, reg_addr);
						reg_wdata <= byte_c;
						if (!cont_q) begin
							state_q <= fin_state;
						end
					end
					D_RD: begin
						rd_ind_q <= 1'b0;
						if (cont_q) begin
							reg_addr <= rhi_next_addr(reg_addr);
							step_q <= 1'b1;
							reg_re <= acc_ok(iface_mode, rhi_next_addr(reg_addr));
						end else begin
							state_q <= fin_state;
						end
					end
					D_IDLE, D_DONE: begin
					end
				endcase
			end
		end
	end

	// read data arrives one cycle after the strobe; blocked reads give zero
	always_ff @(posedge core_clk) begin
		if (srst) begin
			step_d1_q <= 1'b0;
			re_d1_q <= 1'b0;
			tx_q <= 8'h00;
		end else begin
			step_d1_q <= step_q;
			re_d1_q <= reg_re;
			if (step_d1_q) begin
				tx_q <= re_d1_q ? reg_rdata : 8'h00;
			end else if (is_spi && pin_fall[8] && bit_q != 3'h0 && state_q == D_RD) begin
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	// pin drive, by mode
	always_ff @(posedge core_clk) begin
		if (srst || !mode_valid) begin
			out_q <= 8'h00;
			oe_q <= 8'h00;
		end else if (is_par) begin
			out_q <= 8'h00;
			oe_q <= 8'h00;
			if (direct_active) begin
				oe_q[PIN_DDATA] <= 1'b1;
				oe_q[PIN_DSTRB] <= 1'b1;
				out_q[PIN_DDATA] <= direct_data;
				out_q[PIN_DSTRB] <= direct_bitclk;
			end else if (state_q == D_RD && !clk_lvl && !step_q && !step_d1_q) begin
				// drive only while the clock is low so stops stay readable
				oe_q <= 8'hFF;
				out_q <= tx_q;
			end
		end else begin
			out_q <= 8'h00;
			oe_q <= 8'h00;
			oe_q[PIN_MISO] <= iface_mode == RHI_SPI_NOSS || !pin_q[PIN_SS];
			oe_q[PIN_RDIND] <= 1'b1;
			out_q[PIN_MISO] <= tx_q[7];
			out_q[PIN_RDIND] <= rd_ind_q;
		end
	end

	// service request, straight from the core
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_req;
		end
	end

	assign lnk.dev_out = out_q;
	assign lnk.dev_oe = oe_q;
	assign lnk.irq = irq_q;
endmodule // rhi_dev

// ### hw/rhi_pkg.sv
package rhi_pkg;
	// core timing
	localparam int CLK_PERIOD_NS = 5;
	// half period of the link clock made by the host end
	localparam int LINK_HALF_NS = 65;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// cycles after reset before the straps are taken
	localparam int STRAP_WAIT_CYC = 4;
	// cycles after the device lets go of the top line before its edges count
	localparam int PAR_GUARD_CYC = 4;
	// header fields
	localparam int HDR_CMD_BIT = 7;
	localparam int HDR_RD_BIT = 6;
	localparam int HDR_CONT_BIT = 5;
	// pin positions on the eight shared lines
	localparam int PIN_TOP = 7;
	localparam int PIN_MOSI = 7;
	localparam int PIN_MISO = 6;
	localparam int PIN_DDATA = 6;
	localparam int PIN_RDIND = 5;
	localparam int PIN_DSTRB = 5;
	localparam int PIN_SS = 4;
	// strap patterns on the three low lines
	localparam logic [2:0] STRAP_SPI_SS = 3'h6;
	localparam logic [2:0] STRAP_SPI_NOSS = 3'h4;
	localparam logic [2:0] STRAP_PAR = 3'h0;
	// data buffer location and size
	localparam logic [4:0] FIFO_ADDR = 5'h1F;
	localparam int FIFO_DEPTH = 127;
	// pins the host drives while idle in spi modes
	localparam logic [7:0] SPI_HOST_OE = 8'h97;
	localparam logic [7:0] PAR_MARK = 8'h80;

	typedef enum logic [1:0] {
		RHI_PAR = 2'b00,
		RHI_SPI_SS = 2'b01,
		RHI_SPI_NOSS = 2'b10
	} rhi_mode_e;

	// address step: the buffer location does not advance
	function automatic logic [4:0] rhi_next_addr(input logic [4:0] a);
		rhi_next_addr = (a == FIFO_ADDR) ? a : a + 5'h01;
	endfunction
endpackage

// ### hw/rhi_if.sv
`timescale 1ns/1ps
interface rhi_if;
	logic link_clk;
	logic [7:0] dev_out;
	logic [7:0] dev_oe;
	logic [7:0] host_out;
	logic [7:0] host_oe;
	logic irq;
	logic [7:0] io;

	// wire level: device wins, undriven lines read low
	assign io = (dev_oe & dev_out) | (~dev_oe & host_oe & host_out);

	modport device (input link_clk, input io, output dev_out, output dev_oe, output irq);
	modport host (output link_clk, output host_out, output host_oe, input io, input irq);
endinterface

// ### hw/rhi_sync.sv
`timescale 1ns/1ps
module rhi_sync #(
	parameter int W = 9
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// two stages against metastability, third only for edges
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign q = s2_q;
	assign rise = s2_q & ~s3_q;
	assign fall = ~s2_q & s3_q;
endmodule // rhi_sync

// ### hw/rhi_host.sv
`timescale 1ns/1ps
module rhi_host import rhi_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	rhi_if.host lnk,
	input rhi_mode_e iface_sel,
	input wire logic req_valid,
	input wire logic [7:0] req_hdr,
	input wire logic [6:0] req_len,
	output logic req_ready,
	output logic wr_take,
	input wire logic [7:0] wr_data,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic irq
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_START = 3'b001,
		H_LOW = 3'b010,
		H_HIGH = 3'b011,
		H_STOP = 3'b100
	} rhi_hstate_e;

	rhi_hstate_e st_q;
	logic [1:0] sub_q;
	logic [4:0] div_q;
	logic clk_q;
	logic [7:0] out_q;
	logic [7:0] oe_q;
	logic [7:0] sh_q;
	logic [7:0] rx_q;
	logic [2:0] bit_q;
	logic [6:0] left_q;
	logic rd_q;
	logic hdr_q;
	logic [8:0] pin_q;
	logic par;
	logic tick;
	logic [7:0] base_out;
	logic [7:0] base_oe;
	logic [7:0] rx_c;

	rhi_sync #(.W(9)) u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.d({lnk.irq, lnk.io}),
		.q(pin_q),
		.rise(),
		.fall()
	);

	// idle levels: board straps and select high in spi, bus low in parallel
	always_comb begin
		par = iface_sel == RHI_PAR;
		tick = div_q == 5'h00;
		base_out = 8'h00;
		base_oe = 8'hFF;
		if (!par) begin
			base_oe = SPI_HOST_OE;
			base_out[PIN_SS] = 1'b1;
			base_out[2:0] = (iface_sel == RHI_SPI_SS) ? STRAP_SPI_SS : STRAP_SPI_NOSS;
		end
		rx_c = par ? pin_q[7:0] : {rx_q[6:0], pin_q[PIN_MISO]};
	end

	// half-period divider for the link clock
	always_ff @(posedge core_clk) begin
		if (srst || st_q == H_IDLE || tick) begin
			div_q <= 5'(LINK_HALF_CYC - 1);
		end else begin
			div_q <= div_q - 5'h01;
		end
	end

	// host owns every transfer: clock, start and stop
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_q <= H_IDLE;
			sub_q <= 2'h0;
			clk_q <= 1'b0;
			out_q <= base_out;
			oe_q <= base_oe;
			sh_q <= 8'h00;
			rx_q <= 8'h00;
			bit_q <= 3'h0;
			left_q <= 7'h00;
			rd_q <= 1'b0;
			hdr_q <= 1'b0;
			req_ready <= 1'b0;
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			if (wr_take) begin
				sh_q <= wr_data;
			end
			unique case (st_q)
				H_IDLE: begin
					clk_q <= 1'b0;
					out_q <= base_out;
					oe_q <= base_oe;
					req_ready <= 1'b1;
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						sh_q <= req_hdr;
						left_q <= req_len;
						rd_q <= !req_hdr[HDR_CMD_BIT] && req_hdr[HDR_RD_BIT];
						hdr_q <= 1'b1;
						bit_q <= 3'h0;
						sub_q <= 2'h0;
						st_q <= H_START;
					end
				end
				H_START: if (tick) begin
					sub_q <= sub_q + 2'h1;
					if (sub_q == 2'h0) begin
						if (par) begin
							clk_q <= 1'b1;
						end else begin
							out_q[PIN_SS] <= 1'b0;
						end
					end else begin
						if (par) begin
							out_q[PIN_TOP] <= 1'b1;
						end
						st_q <= H_LOW;
					end
				end
				H_LOW: if (tick) begin
					clk_q <= 1'b0;
					if (par) begin
						oe_q <= (hdr_q || !rd_q) ? 8'hFF : 8'h00;
						out_q <= sh_q;
					end else begin
						out_q[PIN_MOSI] <= sh_q[7];
					end
					st_q <= H_HIGH;
				end
				H_HIGH: if (tick) begin
					clk_q <= 1'b1;
					rx_q <= rx_c;
					sh_q <= {sh_q[6:0], 1'b0};
					bit_q <= bit_q + 3'h1;
					st_q <= H_LOW;
					if (par || bit_q == 3'h7) begin
						bit_q <= 3'h0;
						hdr_q <= 1'b0;
						rd_valid <= rd_q && !hdr_q;
						rd_data <= rx_c;
						if (left_q == 7'h00) begin
							sub_q <= 2'h0;
							st_q <= H_STOP;
						end else begin
							left_q <= left_q - 7'h01;
							wr_take <= !rd_q;
						end
					end
				end
				H_STOP: if (tick) begin
					sub_q <= sub_q + 2'h1;
					if (!par) begin
						// clock back to its idle low before the select lets go
						clk_q <= 1'b0;
						if (sub_q != 2'h0) begin
							out_q[PIN_SS] <= 1'b1;
							st_q <= H_IDLE;
						end
					end else if (sub_q == 2'h0) begin
						// raise the top line while the clock is low
						clk_q <= 1'b0;
						oe_q <= 8'hFF;
						out_q <= PAR_MARK;
					end else if (sub_q == 2'h1) begin
						clk_q <= 1'b1;
					end else begin
						out_q[PIN_TOP] <= 1'b0;
						st_q <= H_IDLE;
					end
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end

	// service request seen through the synchroniser
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= pin_q[8];
		end
	end

	assign lnk.link_clk = clk_q;
	assign lnk.host_out = out_q;
	assign lnk.host_oe = oe_q;
endmodule // rhi_host

// ### tb/rhi_asserts.sv
`timescale 1ns/1ps
module rhi_asserts import rhi_pkg::*; (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic link_clk,
	input wire logic [7:0] dev_oe,
	input wire logic [7:0] host_oe,
	input wire logic [7:0] io
);
	logic [2:0] strap_q;
	logic clk_q;
	logic [4:0] edge_q;
	logic spi;
	logic ss;
	// straps are what the host shows while reset is held
	always_ff @(posedge core_clk) begin
		if (srst) strap_q <= io[2:0];
	end
	assign ss = strap_q == STRAP_SPI_SS;
	assign spi = ss || strap_q == STRAP_SPI_NOSS;
	// link clock rises within a frame; select high clears the count
	always_ff @(posedge core_clk) begin
		clk_q <= link_clk;
		if (srst || io[4]) edge_q <= 5'h00;
		else if (link_clk && !clk_q && edge_q != 5'h1F) edge_q <= edge_q + 5'h01;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	a_spi_dev_pins: assert property (spi |-> (dev_oe & 8'h9F) == 8'h00)
		else $error("device drives a host pin in spi mode");
	a_straps_kept: assert property (spi |-> io[2:0] == strap_q)
		else $error("strap lines moved after reset");
	a_ss_clk_idle: assert property (ss && io[4] |-> !link_clk)
		else $error("link clock high outside a frame");
	a_rdind_frame: assert property (ss && io[5] |-> !io[4])
		else $error("read indicator high outside a frame");
	a_rdind_start: assert property (ss && $rose(io[5]) |-> edge_q == 5'h08)
		else $error("read indicator rose away from header end");
	a_rdind_hold: assert property (ss && $rose(io[5]) |-> io[5] [*8])
		else $error("read indicator too short");
	a_rdind_end: assert property (ss && $fell(io[5]) |-> edge_q == 5'h10)
		else $error("read indicator fell away from data byte end");
	// parallel read data may only sit on the lines while the clock is low
	a_par_release: assert property (!spi && link_clk [*6] |-> dev_oe[PIN_TOP] == 1'b0)
		else $error("device holds lines while link clock high");
	// host must let go of every line while the device returns read data
	a_par_no_fight: assert property (!spi && dev_oe[PIN_TOP] |-> host_oe == 8'h00)
		else $error("host and device drive the lines together");
endmodule // rhi_asserts

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import rhi_pkg::*;;
	logic core_clk;
	logic srst = 1'b1;
	rhi_mode_e iface_sel = RHI_SPI_SS;
	logic req_valid = 1'b0;
	logic [7:0] req_hdr = 8'h00;
	logic [6:0] req_len = 7'h00;
	logic req_ready, wr_take, rd_valid, host_irq, mode_valid;
	logic [7:0] rd_data, wr_data, reg_wdata, reg_rdata;
	logic [4:0] reg_addr, cmd_code;
	logic reg_we, reg_re, cmd_valid;
	logic irq_req = 1'b0;
	logic direct_enter = 1'b0, direct_data = 1'b0, direct_bitclk = 1'b0, direct_active;
	rhi_mode_e iface_mode;
	logic [7:0] wbuf [4];
	int wi = 0;
	logic [15:0] we_q[$], cmd_q[$], rd_q[$];
	int n_re = 0;
	int n_mismatch = 0;
	int n_tests = 0;

	rhi_if lnk ();
	rhi_dev rhi_dev_inst (.core_clk(core_clk), .srst(srst), .lnk(lnk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .irq_req(irq_req),
		.direct_enter(direct_enter), .direct_data(direct_data), .direct_bitclk(direct_bitclk),
		.direct_active(direct_active), .mode_valid(mode_valid),
		.iface_mode(iface_mode));
	rhi_host rhi_host_inst (.core_clk(core_clk), .srst(srst), .lnk(lnk), .iface_sel(iface_sel),
		.req_valid(req_valid), .req_hdr(req_hdr), .req_len(req_len), .req_ready(req_ready),
		.wr_take(wr_take), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
		.irq(host_irq));
	rhi_asserts rhi_asserts_inst (.core_clk(core_clk), .srst(srst), .link_clk(lnk.link_clk),
		.dev_oe(lnk.dev_oe), .host_oe(lnk.host_oe), .io(lnk.io));

	// register file stand-in: read data follows the address
	assign reg_rdata = 8'hA0 | {3'h0, reg_addr};
	assign wr_data = wbuf[wi[1:0]];

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// collect what each end hands to its user side
	always @(posedge core_clk) begin
		if (reg_we === 1'b1) we_q.push_back({3'h0, reg_addr, reg_wdata});
		if (reg_re === 1'b1) n_re++;
		if (cmd_valid === 1'b1) cmd_q.push_back({11'h000, cmd_code});
		if (rd_valid === 1'b1) rd_q.push_back({8'h00, rd_data});
		if (wr_take === 1'b1) wi <= wi + 1;
	end

	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic chk_cnt(input string what, input int exp, input int got);
		n_tests++;
		if (got != exp) begin
			n_mismatch++;
			$display("wrong value %s: expected %0d, seen %0d", what, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// straps only count at power up, so a mode change needs a full reset
	task automatic reset_into(input rhi_mode_e m);
		srst = 1'b1;
		iface_sel = m;
		step(16);
		srst = 1'b0;
		step(12);
		chk_val("mode_valid", 16'h0001, {15'h0000, mode_valid});
		chk_val("iface_mode", {14'h0000, m}, {14'h0000, iface_mode});
	endtask

	// one host transaction; waits are bounded so a hang is reported
	task automatic xfer(input logic [7:0] hdr, input logic [6:0] len);
		int i;
		we_q.delete();
		cmd_q.delete();
		rd_q.delete();
		n_re = 0;
		wi = 0;
		i = 0;
		while (req_ready !== 1'b1 && i < 100) begin
			step(1);
			i++;
		end
		req_valid = 1'b1;
		req_hdr = hdr;
		req_len = len;
		step(1);
		req_valid = 1'b0;
		i = 0;
		while (req_ready !== 1'b1 && i < 8000) begin
			step(1);
			i++;
		end
		chk_cnt("transfer done", 1, (i < 8000) ? 1 : 0);
		step(40);
	endtask

	task automatic t_spi_write();
		wbuf[0] = 8'hAB;
		wbuf[1] = 8'hCD;
		xfer(8'h05, 7'h02);
		chk_cnt("single write count", 1, we_q.size());
		chk_val("single write", 16'h05AB, we_q[0]);
	endtask

	task automatic t_spi_read();
		xfer(8'h43, 7'h01);
		chk_cnt("read strobes", 1, n_re);
		chk_val("read data", 16'h00A3, rd_q[0]);
	endtask

	// burst runs into the buffer location at the top of the map
	task automatic t_cont_write();
		wbuf[0] = 8'h11;
		wbuf[1] = 8'h22;
		wbuf[2] = 8'h33;
		xfer(8'h3D, 7'h03);
		chk_cnt("burst count", 3, we_q.size());
		for (int k = 0; k < 3; k++) begin
			chk_val("burst write", {3'h0, 5'h1D + 5'(k), 8'h11 * 8'(k + 1)}, we_q[k]);
		end
	endtask

	task automatic t_cmd();
		logic [7:0] bad [2] = '{8'hAF, 8'hCF};
		xfer(8'h8F, 7'h00);
		chk_cnt("command count", 1, cmd_q.size());
		chk_val("command code", 16'h000F, cmd_q[0]);
		foreach (bad[k]) begin
			xfer(bad[k], 7'h00);
			chk_cnt("bad command", 0, cmd_q.size());
		end
	endtask

	task automatic t_irq();
		irq_req = 1'b1;
		step(8);
		chk_val("irq raised", 16'h0001, {15'h0000, host_irq});
		irq_req = 1'b0;
		step(8);
		chk_val("irq cleared", 16'h0000, {15'h0000, host_irq});
	endtask

	task automatic t_noss();
		reset_into(RHI_SPI_NOSS);
		wbuf[0] = 8'h5E;
		xfer(8'h1F, 7'h01);
		chk_cnt("buffer write refused", 0, we_q.size());
		xfer(8'h02, 7'h01);
		chk_val("plain write", 16'h025E, we_q[0]);
	endtask

	task automatic t_par();
		reset_into(RHI_PAR);
		wbuf[0] = 8'h3C;
		xfer(8'h07, 7'h01);
		chk_val("parallel write", 16'h073C, we_q[0]);
		xfer(8'h49, 7'h01);
		chk_val("parallel read", 16'h00A9, rd_q[0]);
	endtask

	// direct mode puts raw data and strobe on the pins until a simple stop
	task automatic t_direct();
		direct_data = 1'b1;
		direct_bitclk = 1'b1;
		direct_enter = 1'b1;
		step(1);
		direct_enter = 1'b0;
		step(4);
		chk_val("direct active", 16'h0001, {15'h0000, direct_active});
		chk_val("direct pins", 16'h0003, {14'h0000, lnk.io[6:5]});
		xfer(8'h00, 7'h00);
		chk_val("direct left", 16'h0000, {15'h0000, direct_active});
		chk_cnt("direct header ignored", 0, we_q.size() + cmd_q.size());
	endtask

	initial begin
		reset_into(RHI_SPI_SS);
		t_spi_write();
		t_spi_read();
		t_cont_write();
		t_cmd();
		t_irq();
		t_noss();
		t_par();
		t_direct();
		finish_test();
	end

	// watchdog: about thirteen times what the whole run should need
	initial begin
		#300000;
		n_mismatch++;
		finish_test();
	end
endmodule // tb_top
